// ==== load_objects_defs.vh ====
`ifndef LOAD_OBJECTS_DEFS_VH
`define LOAD_OBJECTS_DEFS_VH

// Object indices
`define IDX_QUESTIONABLE     16'h200B
`define IDX_OP_STATUS_LOW    16'h200D
`define IDX_OP_STATUS_HIGH   16'h200E
`define IDX_INPUT_ENABLE     16'h2011
`define IDX_MEAS_CURRENT     16'h2101
`define IDX_MEAS_VOLTAGE     16'h2102
`define IDX_MEAS_POWER       16'h2103
`define IDX_MEAS_RESISTANCE  16'h2104
`define IDX_CURR_TARGET_WR   16'h2201
`define IDX_CURR_TARGET_RB   16'h2202
`define IDX_VOLT_TARGET_WR   16'h2203
`define IDX_VOLT_TARGET_RB   16'h2204
`define IDX_PWR_TARGET_WR    16'h2205
`define IDX_PWR_TARGET_RB    16'h2206
`define IDX_RES_TARGET_WR    16'h2207
`define IDX_RES_TARGET_RB    16'h2208

// Reset values
`define TARGET_RESET         32'h00000000
`define ENABLE_RESET         1'h0

// Regulation mode codes on the mode select input
`define MODE_CC              2'h0
`define MODE_CV              2'h1
`define MODE_CR              2'h2
`define MODE_CP              2'h3

// Questionable word field positions
`define QB_OVP               0
`define QB_OCT               1
`define QB_OVT               2
`define QB_OPT               3
`define QB_OCP               4
`define QB_OTP               5
`define QB_RSL               6
`define QB_MODE_LO           7
`define QB_SOFT_SUM          11
`define QB_HARD_SUM          12
`define QB_INTERLOCK_OPEN_FLAG              13
`define QB_IPL               14
`define QB_IO_LINE_FAULT_FLAG              15

// Documented operation bits with no dedicated source port
`define OPLO_AUX_MASK        32'h5348C200
`define OPHI_AUX_MASK        32'h00030000

`endif

// ==== load_status_setpoint_objects.v ====
`timescale 1ns/10ps
`include "load_objects_defs.vh"

module load_status_setpoint_objects
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_b_i,
  // Indexed object access
  input  wire        req_i,
  input  wire        we_i,
  input  wire [15:0] index_i,
  input  wire [31:0] wdata_i,
  output reg  [31:0] rdata_o,
  output reg         ack_o,
  output reg         err_o,
  // Hard and soft faults, interlock, input power loss and IO line flags (asynchronous)
  input  wire        overvolt_protect_fault_i,
  input  wire        overcurrent_trip_flag_i,
  input  wire        overvolt_trip_flag_i,
  input  wire        overpower_trip_flag_i,
  input  wire        overcurrent_protect_fault_i,
  input  wire        overtemp_protect_fault_i,
  input  wire        sense_loss_fault_i,
  input  wire        interlock_open_flag_i,
  input  wire        input_power_loss_flag_i,
  input  wire        io_line_fault_flag_i,
  // Operation status conditions (asynchronous)
  input  wire        low_voltage_trip_status_i,
  input  wire        sense_out_of_bounds_i,
  input  wire        linear_stage_power_limit_i,
  input  wire        resistor_stage_power_limit_i,
  input  wire        target_start_failed_i,
  input  wire        target_start_pending_i,
  input  wire        linear_module_overheat_i,
  input  wire        diode_module_overheat_i,
  input  wire        resistor_module_overheat_i,
  input  wire        regulation_lost_i,
  input  wire        supply_phase_missing_i,
  input  wire        input_fuse_open_i,
  input  wire        fan_stalled_i,
  input  wire        power_stage_overheat_i,
  input  wire        filter_module_overheat_i,
  input  wire        capacitor_overheat_i,
  input  wire        transformer_overheat_i,
  input  wire [31:0] aux_status_low_i,
  input  wire [31:0] aux_status_high_i,
  // Regulation loop state (same clock)
  input  wire [1:0]  reg_mode_i,
  input  wire        regulating_i,
  input  wire        sense_engaged_i,
  // Averaged measurements (same clock)
  input  wire [31:0] average_current_read_i,
  input  wire [31:0] average_voltage_read_i,
  input  wire [31:0] sense_voltage_read_i,
  input  wire [31:0] average_power_read_i,
  input  wire [31:0] average_resistance_read_i,
  // Outputs to the power stage
  output wire        input_conduct_o,
  output reg  [31:0] active_target_o,
  output reg  [1:0]  active_mode_o,
  output reg         target_valid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [28:0] cond_s1;
  reg  [28:0] cond_s2;
  reg  [63:0] aux_s1;
  reg  [63:0] aux_s2;
  reg         load_input_enable;
  reg  [31:0] current_target;
  reg  [31:0] voltage_target;
  reg  [31:0] power_target;
  reg  [31:0] resistance_target;
  reg  [31:0] questionable_status;
  reg  [31:0] operation_status_low;
  reg  [31:0] operation_status_high;
  reg  [31:0] next_rdata;
  reg         next_err;
  reg  [31:0] next_target;
  wire [3:0]  mode_bits;
  wire [3:0]  soft_bits;
  wire [3:0]  hard_bits;
  wire        wr;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // One-hot loop indicator; a 2-bit code cannot name two loops at once
  function [3:0] mode_onehot;
    input [1:0] mode;
    input       active;
    begin
      mode_onehot = 4'h0;
      if (active)
      begin
        case (mode)
          `MODE_CC: mode_onehot = 4'h1;
          `MODE_CV: mode_onehot = 4'h2;
          `MODE_CR: mode_onehot = 4'h4;
          default:  mode_onehot = 4'h8;
        endcase
      end
    end
  endfunction

  // Target register that belongs to a given loop
  function [31:0] target_for;
    input [1:0]  mode;
    input [31:0] cur;
    input [31:0] vlt;
    input [31:0] pwr;
    input [31:0] res;
    begin
      case (mode)
        `MODE_CC: target_for = cur;
        `MODE_CV: target_for = vlt;
        `MODE_CR: target_for = res;
        default:  target_for = pwr;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  // Fault lines come from other domains; two flops before any decode
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cond_s1 <= 29'h00000000;
      cond_s2 <= 29'h00000000;
      aux_s1  <= 64'h0000000000000000;
      aux_s2  <= 64'h0000000000000000;
    end
    else
    begin
      cond_s1 <= {transformer_overheat_i, capacitor_overheat_i,
                  filter_module_overheat_i, power_stage_overheat_i,
                  fan_stalled_i, input_fuse_open_i,
                  supply_phase_missing_i, regulation_lost_i,
                  resistor_module_overheat_i, diode_module_overheat_i,
                  linear_module_overheat_i, target_start_pending_i,
                  target_start_failed_i, resistor_stage_power_limit_i,
                  linear_stage_power_limit_i, sense_out_of_bounds_i,
                  low_voltage_trip_status_i, io_line_fault_flag_i,
                  input_power_loss_flag_i, interlock_open_flag_i,
                  sense_loss_fault_i, overtemp_protect_fault_i,
                  overcurrent_protect_fault_i, overpower_trip_flag_i,
                  overvolt_trip_flag_i, overcurrent_trip_flag_i,
                  overvolt_protect_fault_i, 2'h0};
      cond_s2 <= cond_s1;
      aux_s1  <= {aux_status_high_i, aux_status_low_i};
      aux_s2  <= aux_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Live status words

  // Loop indicator only while the input conducts and the loop regulates
  assign mode_bits = mode_onehot(reg_mode_i,
                                 regulating_i & load_input_enable);
  assign soft_bits = {1'b0, cond_s2[5], cond_s2[4], cond_s2[3]};
  assign hard_bits = {cond_s2[8], cond_s2[7], cond_s2[6], cond_s2[2]};

  // Rebuilt every cycle from live inputs, so nothing is latched
  always @*
  begin
    questionable_status                 = 32'h00000000;
    questionable_status[`QB_OVP]        = cond_s2[2];
    questionable_status[`QB_OCT]        = cond_s2[3];
    questionable_status[`QB_OVT]        = cond_s2[4];
    questionable_status[`QB_OPT]        = cond_s2[5];
    questionable_status[`QB_OCP]        = cond_s2[6];
    questionable_status[`QB_OTP]        = cond_s2[7];
    questionable_status[`QB_RSL]        = cond_s2[8];
    questionable_status[10:7]           = mode_bits;
    questionable_status[`QB_SOFT_SUM]   = |soft_bits;
    questionable_status[`QB_HARD_SUM]   = |hard_bits;
    questionable_status[`QB_INTERLOCK_OPEN_FLAG]       = cond_s2[9];
    questionable_status[`QB_IPL]        = cond_s2[10];
    questionable_status[`QB_IO_LINE_FAULT_FLAG]       = cond_s2[11];
  end

  // Same sources feed both maps so the two words always agree
  always @*
  begin
    operation_status_low       = aux_s2[31:0] & `OPLO_AUX_MASK;
    operation_status_low[0]    = ~load_input_enable;
    operation_status_low[1]    = load_input_enable;
    operation_status_low[4]    = cond_s2[3];
    operation_status_low[5]    = cond_s2[4];
    operation_status_low[6]    = cond_s2[5];
    operation_status_low[7]    = cond_s2[13];
    operation_status_low[8]    = cond_s2[12];
    operation_status_low[10]   = cond_s2[14];
    operation_status_low[11]   = cond_s2[15];
    operation_status_low[12]   = cond_s2[16];
    operation_status_low[13]   = cond_s2[17];
    operation_status_low[16]   = cond_s2[6];
    operation_status_low[17]   = cond_s2[2];
    operation_status_low[18]   = cond_s2[18];
    operation_status_low[20]   = cond_s2[9];
    operation_status_low[23]   = cond_s2[19];
    operation_status_low[26]   = cond_s2[11];
    operation_status_low[27]   = cond_s2[20];
    operation_status_low[29]   = cond_s2[21];
    operation_status_high      = aux_s2[63:32] & `OPHI_AUX_MASK;
    operation_status_high[0]   = cond_s2[22];
    operation_status_high[1]   = cond_s2[23];
    operation_status_high[2]   = cond_s2[24];
    operation_status_high[4]   = cond_s2[25];
    operation_status_high[5]   = cond_s2[26];
    operation_status_high[6]   = cond_s2[27];
    operation_status_high[7]   = cond_s2[28];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Object read decode

  // Reads have no side effect; status words are sampled, never cleared
  always @*
  begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    if (we_i)
    begin
      case (index_i)
        `IDX_INPUT_ENABLE,
        `IDX_CURR_TARGET_WR,
        `IDX_VOLT_TARGET_WR,
        `IDX_PWR_TARGET_WR,
        `IDX_RES_TARGET_WR: next_err = 1'b0;
        default:            next_err = 1'b1;
      endcase
    end
    else
    begin
      case (index_i)
        `IDX_QUESTIONABLE:    next_rdata = questionable_status;
        `IDX_OP_STATUS_LOW:   next_rdata = operation_status_low;
        `IDX_OP_STATUS_HIGH:  next_rdata = operation_status_high;
        `IDX_INPUT_ENABLE:    next_rdata = {31'h0, load_input_enable};
        `IDX_MEAS_CURRENT:    next_rdata = average_current_read_i;
        `IDX_MEAS_VOLTAGE:
          next_rdata = sense_engaged_i ? sense_voltage_read_i
                                       : average_voltage_read_i;
        `IDX_MEAS_POWER:      next_rdata = average_power_read_i;
        `IDX_MEAS_RESISTANCE: next_rdata = average_resistance_read_i;
        `IDX_CURR_TARGET_WR,
        `IDX_CURR_TARGET_RB:  next_rdata = current_target;
        `IDX_VOLT_TARGET_WR,
        `IDX_VOLT_TARGET_RB:  next_rdata = voltage_target;
        `IDX_PWR_TARGET_WR,
        `IDX_PWR_TARGET_RB:   next_rdata = power_target;
        `IDX_RES_TARGET_WR,
        `IDX_RES_TARGET_RB:   next_rdata = resistance_target;
        default:              next_err   = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer register

  // One answer per request, one cycle later
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
      rdata_o <= 32'h00000000;
    end
    else
    begin
      ack_o   <= req_i;
      err_o   <= req_i & next_err;
      rdata_o <= req_i ? next_rdata : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable objects

  assign wr = req_i & we_i;

  // Readback indices refuse writes, so only the write index stores
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      load_input_enable <= `ENABLE_RESET;
      current_target    <= `TARGET_RESET;
      voltage_target    <= `TARGET_RESET;
      power_target      <= `TARGET_RESET;
      resistance_target <= `TARGET_RESET;
    end
    else if (wr)
    begin
      case (index_i)
        `IDX_INPUT_ENABLE:   load_input_enable <= wdata_i[0];
        `IDX_CURR_TARGET_WR: current_target    <= wdata_i;
        `IDX_VOLT_TARGET_WR: voltage_target    <= wdata_i;
        `IDX_PWR_TARGET_WR:  power_target      <= wdata_i;
        `IDX_RES_TARGET_WR:  resistance_target <= wdata_i;
        default:             load_input_enable <= load_input_enable;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Regulation target

  // Low means the power stage holds its input high-impedance
  assign input_conduct_o = load_input_enable;

  always @*
  begin
    next_target = target_for(reg_mode_i, current_target, voltage_target,
                             power_target, resistance_target);
  end

  // Registered so the loop never sees a half-switched target
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      active_target_o <= `TARGET_RESET;
      active_mode_o   <= `MODE_CC;
      target_valid_o  <= 1'b0;
    end
    else
    begin
      active_target_o <= next_target;
      active_mode_o   <= reg_mode_i;
      target_valid_o  <= load_input_enable & regulating_i;
    end
  end

endmodule

// ==== load_objects_checker.sv ====
`timescale 1ns/10ps
`include "load_objects_defs.vh"
module load_objects_checker
(
  // Clock and reset
  input wire        clk_i,
  input wire        rst_b_i,
  // Object access
  input wire        req_i,
  input wire        we_i,
  input wire [15:0] index_i,
  input wire [31:0] wdata_i,
  input wire [31:0] rdata_o,
  input wire        ack_o,
  input wire        err_o,
  // Loop state and power stage side
  input wire [1:0]  reg_mode_i,
  input wire        regulating_i,
  input wire        input_conduct_o,
  input wire [1:0]  active_mode_o,
  input wire        target_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////
  // Tags the answer of a questionable-word read
  reg ques_q;
  always @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
      ques_q <= 1'b0;
    else
      ques_q <= req_i && !we_i && index_i == `IDX_QUESTIONABLE;
  wire ques_rd = ack_o && ques_q;
  // Only these five indices take a write
  wire wr_ok = index_i == `IDX_INPUT_ENABLE ||
               index_i == `IDX_CURR_TARGET_WR ||
               index_i == `IDX_VOLT_TARGET_WR ||
               index_i == `IDX_PWR_TARGET_WR ||
               index_i == `IDX_RES_TARGET_WR;
  ////////////////////////////////////////////////////////////////////////
  AST_ACK_ONE_CYCLE: assert property (
    $past(rst_b_i) |-> ack_o == $past(req_i))
    else $error("answer strobe does not trail the request");
  AST_ERR_WITH_ACK: assert property (err_o |-> ack_o)
    else $error("refusal seen without answer strobe");
  AST_IDLE_DATA_ZERO: assert property (
    !ack_o |-> rdata_o == 32'h0)
    else $error("read data not zero outside an answer");
  AST_BAD_WRITE: assert property (
    req_i && we_i && !wr_ok |=> err_o && rdata_o == 32'h0)
    else $error("write to a read-only index not refused");
  AST_GOOD_WRITE: assert property (
    req_i && we_i && wr_ok |=> ack_o && !err_o)
    else $error("write to a writable index refused");
  AST_ENABLE_WRITE: assert property (
    req_i && we_i && index_i == `IDX_INPUT_ENABLE ##2 1
    |-> input_conduct_o == $past(wdata_i[0], 2))
    else $error("input conduction does not follow enable write");
  AST_READ_KEEPS: assert property (
    req_i && !we_i && !$past(req_i && we_i) |=> $stable(input_conduct_o))
    else $error("a read changed the input enable");
  AST_VALID: assert property (
    $past(rst_b_i) |->
    target_valid_o == $past(input_conduct_o && regulating_i))
    else $error("target valid not enable and regulating");
  AST_MODE: assert property (
    $past(rst_b_i) |-> active_mode_o == $past(reg_mode_i))
    else $error("active mode does not follow mode select");
  AST_SOFT_SUM: assert property (
    ques_rd |-> rdata_o[11] == |rdata_o[3:1])
    else $error("soft summary differs from soft faults");
  AST_HARD_SUM: assert property (
    ques_rd |-> rdata_o[12] == (rdata_o[0] | |rdata_o[6:4]))
    else $error("hard summary differs from hard faults");
  AST_ONE_MODE: assert property (
    ques_rd |-> $onehot0(rdata_o[10:7]) && rdata_o[31:16] == 16'h0)
    else $error("questionable mode bits or upper half wrong");
endmodule
bind load_status_setpoint_objects load_objects_checker chk_u
(
  .clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .we_i(we_i),
  .index_i(index_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ack_o(ack_o),
  .err_o(err_o), .reg_mode_i(reg_mode_i), .regulating_i(regulating_i),
  .input_conduct_o(input_conduct_o), .active_mode_o(active_mode_o),
  .target_valid_o(target_valid_o)
);

// ==== load_host_model.sv ====
`timescale 1ns/10ps
module load_host_model
(
  // Clock
  input  wire         clk_i,
  // Requests toward the bank
  output logic        req_i,
  output logic        we_i,
  output logic [15:0] index_i,
  output logic [31:0] wdata_i,
  // Answers from the bank
  input  wire  [31:0] rdata_o,
  input  wire         ack_o,
  input  wire         err_o
);
  initial
  begin
    req_i = 1'b0;
    we_i = 1'b0;
    index_i = 16'h0;
    wdata_i = 32'h0;
  end
  // One transfer: single-cycle request, answer read where it stands
  task automatic xfer(input logic w, input logic [15:0] ix,
                      input logic [31:0] d, output logic [33:0] ans);
    int n;
    @(negedge clk_i);
    req_i = 1'b1;
    we_i = w;
    index_i = ix;
    wdata_i = d;
    @(negedge clk_i);
    req_i = 1'b0;
    // Released lines carry junk so stale values cannot pass
    we_i = ~w;
    index_i = ~ix;
    wdata_i = ~d;
    n = 0;
    while (ack_o !== 1'b1 && n < 4)
    begin
      @(negedge clk_i);
      n++;
    end
    ans = {ack_o, err_o, rdata_o};
  endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps
`include "load_objects_defs.vh"
module tb;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        req_i, we_i, ack_o, err_o, input_conduct_o, target_valid_o;
  logic        rg, se, en;
  logic [1:0]  active_mode_o, md;
  logic [15:0] index_i;
  logic [26:0] c;
  logic [31:0] wdata_i, rdata_o, active_target_o, al, ah;
  logic [31:0] m [5];
  logic [31:0] tgt [4];
  logic [15:0] tbl [18] = '{16'h200B, 16'h200D, 16'h200E, 16'h2011,
    16'h2101, 16'h2102, 16'h2103, 16'h2104, 16'h2201, 16'h2202, 16'h2203,
    16'h2204, 16'h2205, 16'h2206, 16'h2207, 16'h2208, 16'h2300, 16'h200C};
  int          mismatches = 0;
  int          checks = 0;
  always #2 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  load_host_model host_u (.*);
  load_status_setpoint_objects dut_u
  (
    .*,
    .overvolt_protect_fault_i(c[0]), .overcurrent_trip_flag_i(c[1]),
    .overvolt_trip_flag_i(c[2]), .overpower_trip_flag_i(c[3]),
    .overcurrent_protect_fault_i(c[4]), .overtemp_protect_fault_i(c[5]),
    .sense_loss_fault_i(c[6]), .interlock_open_flag_i(c[7]),
    .input_power_loss_flag_i(c[8]), .io_line_fault_flag_i(c[9]),
    .low_voltage_trip_status_i(c[10]), .sense_out_of_bounds_i(c[11]),
    .linear_stage_power_limit_i(c[12]),
    .resistor_stage_power_limit_i(c[13]), .target_start_failed_i(c[14]),
    .target_start_pending_i(c[15]), .linear_module_overheat_i(c[16]),
    .diode_module_overheat_i(c[17]), .resistor_module_overheat_i(c[18]),
    .regulation_lost_i(c[19]), .supply_phase_missing_i(c[20]),
    .input_fuse_open_i(c[21]), .fan_stalled_i(c[22]),
    .power_stage_overheat_i(c[23]), .filter_module_overheat_i(c[24]),
    .capacitor_overheat_i(c[25]), .transformer_overheat_i(c[26]),
    .aux_status_low_i(al), .aux_status_high_i(ah), .reg_mode_i(md),
    .regulating_i(rg), .sense_engaged_i(se),
    .average_current_read_i(m[0]), .average_voltage_read_i(m[1]),
    .average_power_read_i(m[2]), .average_resistance_read_i(m[3]),
    .sense_voltage_read_i(m[4])
  );
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [63:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Reference model: {ack, err, data}, updating enable and targets
  function automatic logic [33:0] model(input logic w,
                                        input logic [15:0] ix,
                                        input logic [31:0] d);
    logic [3:0]  o;
    logic        sp;
    logic [31:0] q, lo;
    o = ix[3:0] - 4'h1;
    sp = ix[15:4] == 12'h220 && ix[3:0] inside {[1:8]};
    q = {16'h0, c[9:7], c[0] | (|c[6:4]), |c[3:1],
         (en && rg) ? 4'h1 << md : 4'h0, c[6:0]};
    lo = {2'h0, c[19], 1'h0, c[18], c[9], 2'h0, c[17], 2'h0, c[7], 1'h0,
          c[16], c[0], c[4], 2'h0, c[15:12], 1'h0, c[10], c[11], c[3:1],
          2'h0, en, ~en} | al;
    model = {2'b10, 32'h0};
    if (w)
    begin
      if (ix == `IDX_INPUT_ENABLE)
        en = d[0];
      else if (sp && !o[0])
        tgt[o[2:1]] = d;
      else
        model = {2'b11, 32'h0};
    end
    else
      case (ix)
        `IDX_QUESTIONABLE: model[31:0] = q;
        `IDX_OP_STATUS_LOW: model[31:0] = lo;
        `IDX_OP_STATUS_HIGH: model[31:0] = {14'h0, ah[17:16], 8'h0,
          c[26:23], 1'h0, c[22:20]};
        `IDX_INPUT_ENABLE: model[0] = en;
        `IDX_MEAS_CURRENT: model[31:0] = m[0];
        `IDX_MEAS_VOLTAGE: model[31:0] = se ? m[4] : m[1];
        `IDX_MEAS_POWER: model[31:0] = m[2];
        `IDX_MEAS_RESISTANCE: model[31:0] = m[3];
        default: model = sp ? {2'b10, tgt[o[2:1]]} : {2'b11, 32'h0};
      endcase
  endfunction
  // Transfer, compare answer, then compare power stage outputs
  task automatic access(input logic w, input logic [15:0] ix,
                        input logic [31:0] d);
    logic [33:0] ans, exp;
    exp = model(w, ix, d);
    host_u.xfer(w, ix, d, ans);
    if (ans[33] !== 1'b1)
    begin
      check("answer strobe", 64'(ans[33]), 64'h1);
      results();
    end
    check("answer", 64'(ans), 64'(exp));
    repeat (3) @(negedge clk_i);
    check("stage", {active_target_o, input_conduct_o, target_valid_o,
      active_mode_o}, {tgt[{md[1], ^md}], en, en & rg, md});
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Random status and measurements, six transfers per setting
  initial
  begin
    void'($urandom(10770));
    {c, al, ah, md, rg, se, en} = '0;
    m = '{default: 32'h0};
    tgt = '{default: 32'h0};
    repeat (4) @(negedge clk_i);
    rst_b_i = 1'b1;
    for (int it = 0; it < 60; it++)
    begin
      @(negedge clk_i);
      if (it == 30)
      begin
        rst_b_i = 1'b0;
        en = 1'b0;
        tgt = '{default: 32'h0};
        repeat (4) @(negedge clk_i);
        rst_b_i = 1'b1;
      end
      c = 27'($urandom & $urandom);
      al = $urandom & 32'h5348C200;
      ah = $urandom & 32'h00030000;
      {md, rg, se} = 4'($urandom);
      foreach (m[i])
        m[i] = $urandom;
      repeat (4) @(negedge clk_i);
      repeat (6)
        access(1'($urandom), tbl[$urandom_range(17)], $urandom);
    end
    results();
  end
endmodule
